// [logic/sfpc_top.sv]
// Program control of a serial flash: page program, sequential program, write enable latch.
// Assumes SPI mode 0 on spi_sck; spi_sck stands still while spi_cs_n is high.
// Notes on behaviour
// - Page program writes one to 256 bytes into erased locations.
// - Page program runs only when the write enable latch is set.
// - Page program opcode, address and data all arrive on the input line.
// - Eight clocks bring the page program opcode, MSB first, then decoded.
// - A 24-bit start address follows over 24 clocks, bit 23 first.
// - Data bytes MSB first; unsent page locations stay FFh.
// - Chip select release starts self-timed copy; one byte uses byte time.
// - Busy shows in bit 0 of the status byte while programming.
// - Release off a byte boundary aborts and programs nothing.
// - Any aborted program clears the write enable latch.
// - Protected memory: no program, back to idle at release.
// - Unaligned start: bytes past page end wrap to page start.
// - More than 256 data bytes: only the last 256 are kept.
// - Incomplete address or partial data byte aborts, clearing the latch.
// - Sequential mode keeps an internal counter of the next byte address.
// - First sequential command refused unless the write enable latch is set.
// - First sequential command carries opcode, address and data; ADh or AFh.
// - Later sequential commands carry opcode and data only.
// - Initial sequential transfer: opcode, 24 address clocks, one data byte.
// - Release after initial sequential transfer programs that byte at the address.
// - Sequential mode needs no fresh write enable per byte.
// - Several bytes in one sequential cycle: only the last is programmed.
`timescale 1ns/1ps
`default_nettype none

module sfpc_top #(
  parameter int PP_CYCLES = sfpc_pkg::PAGE_PROGRAM_CYCLES,
  parameter int BP_CYCLES = sfpc_pkg::BYTE_PROGRAM_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  input wire logic array_protected,
  output var sfpc_pkg::sfpc_wr_t arr_wr_q,
  output logic arr_wr_valid_q,
  output logic [7:0] status_q,
  output logic busy_flag_q,
  output logic write_enable_latch_q,
  output logic seq_mode_q
);

  // ****************************************************
  // Elaboration checks
  // ****************************************************
  if (PP_CYCLES < 1 || BP_CYCLES < 1) begin : g_bad_time
    $error("Program cycle counts must be at least one");
  end

  // ****************************************************
  // Link domain: shifting and buffering on spi_sck
  // ****************************************************
  logic first_q;
  logic frame_tog_q;
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic [15:0] byte_cnt_q;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  logic [7:0] wptr_q;
  logic [7:0] last_q;
  logic [7:0] page_mem [sfpc_pkg::PAGE_BYTES];
  logic [sfpc_pkg::PAGE_BYTES-1:0] valid_q;
  logic seq_link_q;

  wire logic [7:0] rx_byte = {sh_q, spi_si};
  wire logic byte_done = !first_q && bit_q == 3'h7;
  wire logic op_is_seq = opcode_q == sfpc_pkg::OP_SEQ_PROG_A ||
                         opcode_q == sfpc_pkg::OP_SEQ_PROG_B;
  // Later sequential cycles skip the address phase
  wire logic short_fmt = op_is_seq && seq_link_q;
  wire logic in_addr = !short_fmt && byte_cnt_q >= 16'h0001 &&
                       byte_cnt_q < sfpc_pkg::ADDR_END_BYTE;
  wire logic in_data = short_fmt ? byte_cnt_q >= sfpc_pkg::SHORT_END_BYTE
                                 : byte_cnt_q >= sfpc_pkg::ADDR_END_BYTE;
  wire logic last_addr = in_addr && byte_cnt_q == sfpc_pkg::ADDR_END_BYTE - 16'h0001;
  wire logic pp_data = in_data && opcode_q == sfpc_pkg::OP_PAGE_PROG;

  // Frame start marker; chip select high forces it, so no edge after a frame is needed
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // Toggle tells the core domain that the frame carried clocks
  always_ff @(posedge spi_sck or negedge rst_n) begin
    if (!rst_n) begin
      frame_tog_q <= 1'b0;
    end else if (first_q) begin
      frame_tog_q <= !frame_tog_q;
    end
  end

  // Bit and byte counters, MSB first shift
  always_ff @(posedge spi_sck) begin
    if (first_q) begin
      bit_q <= 3'h1;
      byte_cnt_q <= 16'h0000;
    end else begin
      bit_q <= bit_q + 3'h1;
      if (byte_done && byte_cnt_q != 16'hFFFF) begin
        byte_cnt_q <= byte_cnt_q + 16'h0001;
      end
    end
    sh_q <= first_q ? {6'h00, spi_si} : rx_byte[6:0];
  end

  // Opcode, address and data capture on byte completion
  always_ff @(posedge spi_sck) begin
    if (byte_done && byte_cnt_q == 16'h0000) begin
      opcode_q <= rx_byte;
    end
    if (byte_done && in_addr) begin
      addr_q <= {addr_q[15:0], rx_byte};
    end
    if (byte_done && in_data) begin
      last_q <= rx_byte;
    end
  end

  // Buffer write pointer: starts at the low address byte and wraps inside the page
  always_ff @(posedge spi_sck) begin
    if (byte_done && last_addr) begin
      wptr_q <= rx_byte;
    end else if (byte_done && pp_data) begin
      wptr_q <= wptr_q + 8'h01;
    end
  end

  // Page buffer; overwriting on wrap keeps the last 256 bytes
  always_ff @(posedge spi_sck) begin
    if (byte_done && pp_data) begin
      page_mem[wptr_q] <= rx_byte;
    end
  end

  // Valid marks, cleared each frame so untouched locations stay erased
  always_ff @(posedge spi_sck) begin
    if (first_q) begin
      valid_q <= '0;
    end else if (byte_done && pp_data) begin
      valid_q[wptr_q] <= 1'b1;
    end
  end

  // Sequential mode level into the link domain, three stages with agreement
  logic [2:0] seq_sync_q;
  always_ff @(posedge spi_sck) begin
    seq_sync_q <= {seq_sync_q[1:0], seq_mode_q};
    if (seq_sync_q[1] == seq_sync_q[2]) begin
      seq_link_q <= seq_sync_q[2];
    end
  end

  // ****************************************************
  // Core domain: pin synchronisers
  // ****************************************************
  // Bits: 2 chip select, 1 frame toggle, 0 protection
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] filt_q;
  logic seen_tog_q;

  wire logic [2:0] agree = ~(s2_q ^ s3_q);
  wire logic [2:0] filt_d = (agree & s3_q) | (~agree & filt_q);

  // A change counts once the second and third stages agree
  always_ff @(posedge clock) begin
    s1_q <= {spi_cs_n, frame_tog_q, array_protected};
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (!rst_n) begin
      filt_q <= 3'b100;
    end else begin
      filt_q <= filt_d;
    end
  end

  // ****************************************************
  // Core domain: end-of-frame decode
  // ****************************************************
  // Link registers are read only after release has crossed, when spi_sck is still
  wire logic frame_end = filt_d[2] && !filt_q[2];
  wire logic had_clocks = filt_q[1] != seen_tog_q;
  wire logic whole = bit_q == 3'h0;
  wire logic prot = filt_q[0];
  wire logic pp_cmd = opcode_q == sfpc_pkg::OP_PAGE_PROG && byte_cnt_q != 16'h0000;
  wire logic seq_cmd = op_is_seq && byte_cnt_q != 16'h0000;
  wire logic pp_full = byte_cnt_q > sfpc_pkg::ADDR_END_BYTE;
  wire logic seq_full = seq_mode_q ? byte_cnt_q > sfpc_pkg::SHORT_END_BYTE
                                   : byte_cnt_q > sfpc_pkg::ADDR_END_BYTE;
  wire logic idle_ok = frame_end && had_clocks && !busy_flag_q;
  // Not allowed while sequential mode is active
  wire logic pp_try = idle_ok && pp_cmd && !seq_mode_q && write_enable_latch_q;
  wire logic pp_go = pp_try && whole && pp_full && !prot;
  wire logic seq_try = idle_ok && seq_cmd && write_enable_latch_q;
  wire logic seq_go = seq_try && whole && seq_full && !prot;
  wire logic abort = (pp_try && !pp_go) || (seq_try && !seq_go);
  wire logic wren = idle_ok && whole && opcode_q == sfpc_pkg::OP_WRITE_EN &&
                    byte_cnt_q == sfpc_pkg::SHORT_END_BYTE;
  wire logic wrdi = idle_ok && whole && opcode_q == sfpc_pkg::OP_WRITE_DIS &&
                    byte_cnt_q == sfpc_pkg::SHORT_END_BYTE;
  wire logic single = byte_cnt_q == sfpc_pkg::ADDR_END_BYTE + 16'h0001;

  // ****************************************************
  // Core domain: self-timed program sequencer
  // ****************************************************
  sfpc_pkg::sfpc_state_t state_q;
  sfpc_pkg::sfpc_state_t state_d;
  logic [7:0] idx_q;
  logic [31:0] wait_q;
  logic [23:0] seq_addr_q;
  logic [23:0] page_base_q;
  logic done_prog;
  logic pp_run_q;

  wire logic [23:0] seq_target = seq_mode_q ? seq_addr_q : addr_q;
  wire logic copy_end = state_q == sfpc_pkg::SFPC_COPY && idx_q == 8'hFF;
  wire logic [31:0] pp_len = pp_run_q && !single ? PP_CYCLES : BP_CYCLES;

  // Next state
  always_comb begin
    state_d = state_q;
    done_prog = 1'b0;
    unique case (state_q)
      sfpc_pkg::SFPC_IDLE: begin
        if (pp_go) begin
          state_d = sfpc_pkg::SFPC_COPY;
        end else if (seq_go) begin
          state_d = sfpc_pkg::SFPC_WAIT;
        end
      end
      sfpc_pkg::SFPC_COPY: begin
        if (copy_end) begin
          state_d = sfpc_pkg::SFPC_WAIT;
        end
      end
      sfpc_pkg::SFPC_WAIT: begin
        if (wait_q == 32'h0000_0001) begin
          state_d = sfpc_pkg::SFPC_IDLE;
          done_prog = 1'b1;
        end
      end
      default: begin
        state_d = sfpc_pkg::SFPC_IDLE;
      end
    endcase
  end

  // State, copy index and wait counter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= sfpc_pkg::SFPC_IDLE;
      idx_q <= 8'h00;
      wait_q <= 32'h0000_0000;
      pp_run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= state_q == sfpc_pkg::SFPC_COPY ? idx_q + 8'h01 : 8'h00;
      if (pp_go) begin
        pp_run_q <= 1'b1;
      end else if (seq_go) begin
        pp_run_q <= 1'b0;
        wait_q <= BP_CYCLES;
      end else if (copy_end) begin
        wait_q <= pp_len;
      end else if (state_q == sfpc_pkg::SFPC_WAIT) begin
        wait_q <= wait_q - 32'h0000_0001;
      end
    end
  end

  // Frame bookkeeping and sequential address counter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seen_tog_q <= 1'b0;
      seq_addr_q <= sfpc_pkg::ADDR_RST;
      page_base_q <= sfpc_pkg::ADDR_RST;
    end else begin
      if (frame_end) begin
        seen_tog_q <= filt_q[1];
      end
      if (pp_go) begin
        page_base_q <= addr_q;
      end
      if (seq_go) begin
        seq_addr_q <= seq_target + 24'h000001;
      end
    end
  end

  // Array write port; the copy drains the buffer well before a new frame reaches data
  wire logic copy_hit = state_q == sfpc_pkg::SFPC_COPY && valid_q[idx_q];
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arr_wr_valid_q <= 1'b0;
      arr_wr_q <= '{addr: sfpc_pkg::ADDR_RST, data: sfpc_pkg::ERASED_BYTE};
    end else begin
      arr_wr_valid_q <= copy_hit || seq_go;
      if (copy_hit) begin
        arr_wr_q <= '{addr: {page_base_q[23:8], idx_q}, data: page_mem[idx_q]};
      end else if (seq_go) begin
        arr_wr_q <= '{addr: seq_target, data: last_q};
      end
    end
  end

  // ****************************************************
  // Core domain: latch, mode and status
  // ****************************************************
  // Page program drops the latch as it finishes; sequential mode keeps it
  wire logic latch_clr = abort || wrdi || (done_prog && pp_run_q);
  wire logic write_enable_latch_d = latch_clr ? 1'b0 : (wren ? 1'b1 : write_enable_latch_q);
  wire logic seq_mode_d = (abort || wrdi) ? 1'b0 : (seq_go ? 1'b1 : seq_mode_q);
  wire logic busy_flag_d = (pp_go || seq_go) ? 1'b1 : (done_prog ? 1'b0 : busy_flag_q);
  // Flags and status image share next values, so the status byte never lags
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      write_enable_latch_q <= 1'b0;
      seq_mode_q <= 1'b0;
      busy_flag_q <= 1'b0;
    end else begin
      write_enable_latch_q <= write_enable_latch_d;
      seq_mode_q <= seq_mode_d;
      busy_flag_q <= busy_flag_d;
    end
  end

  // Status byte image; the lane of bit 0 carries busy
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_q <= 8'h00;
    end else begin
      status_q <= 8'h00;
      status_q[sfpc_pkg::BUSY_BIT] <= busy_flag_d;
      status_q[sfpc_pkg::LATCH_BIT] <= write_enable_latch_d;
      status_q[sfpc_pkg::SEQ_BIT] <= seq_mode_d;
    end
  end

endmodule : sfpc_top

`default_nettype wire

// [pkg/sfpc_pkg.sv]
// Constants, types and states for the serial flash program control block.
// Assumes a single-lane SPI host and an array macro that takes one byte write per cycle.
`default_nettype none

package sfpc_pkg;

  // ****************************************************
  // Opcodes
  // ****************************************************
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_SEQ_PROG_A = 8'hAD;
  localparam logic [7:0] OP_SEQ_PROG_B = 8'hAF;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS = 8'h04;

  // ****************************************************
  // Framing, reset values, status positions
  // ****************************************************
  localparam int PAGE_BYTES = 256;
  localparam logic [15:0] ADDR_END_BYTE = 16'h0004; // Opcode plus three address bytes
  localparam logic [15:0] SHORT_END_BYTE = 16'h0001; // Opcode only, no address
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam int SEQ_BIT = 2;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [23:0] ADDR_RST = 24'h000000;

  // ****************************************************
  // Self-timed program durations
  // ****************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int PAGE_PROGRAM_TIME_US = 1000;
  localparam int BYTE_PROGRAM_TIME_US = 30;
  localparam int PAGE_PROGRAM_CYCLES = (PAGE_PROGRAM_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int BYTE_PROGRAM_CYCLES = (BYTE_PROGRAM_TIME_US * 1000) / CLK_PERIOD_NS;

  // ****************************************************
  // Types
  // ****************************************************
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
  } sfpc_wr_t;

  typedef enum logic [2:0] {
    SFPC_IDLE = 3'b001,
    SFPC_COPY = 3'b010,
    SFPC_WAIT = 3'b100
  } sfpc_state_t;

endpackage : sfpc_pkg

`default_nettype wire

// [tb/serial_flash_program_control_tb.sv]
// Self-checking bench: host model, array write capture, one task per scenario.
// Assumes the package, the design, the host model and the checker compile first.
`timescale 1ns/1ps
`default_nettype none

module serial_flash_program_control_tb;
  localparam int PP = 20;
  localparam int BP = 5;
  logic clock, rst_n, array_protected;
  logic spi_sck, spi_cs_n, spi_si;
  sfpc_pkg::sfpc_wr_t arr_wr_q;
  logic arr_wr_valid_q, busy_flag_q, write_enable_latch_q, seq_mode_q;
  logic [7:0] status_q;
  logic [7:0] got [256];
  logic [7:0] exp_b [256];
  logic [15:0] got_hi;
  int mismatches, comparisons, nwr, blen, len3;

  sfpc_top #(.PP_CYCLES(PP), .BP_CYCLES(BP)) uut (
    .clock(clock), .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
    .array_protected(array_protected), .arr_wr_q(arr_wr_q), .arr_wr_valid_q(arr_wr_valid_q),
    .status_q(status_q), .busy_flag_q(busy_flag_q),
    .write_enable_latch_q(write_enable_latch_q), .seq_mode_q(seq_mode_q));
  sfpc_host host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si));

  // Core clock, 8 ns
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Record array writes and busy cycles for the scenarios to judge
  always @(posedge clock) begin
    if (arr_wr_valid_q === 1'b1) begin
      got[arr_wr_q.addr[7:0]] <= arr_wr_q.data;
      got_hi <= arr_wr_q.addr[23:8];
      nwr <= nwr + 1;
    end
    if (busy_flag_q === 1'b1) blen <= blen + 1;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // Untouched locations read as erased
  task automatic clear();
    for (int i = 0; i < 256; i++) got[i] = 8'hFF;
    nwr = 0;
    blen = 0;
  endtask : clear

  // One frame, then wait out judgement and any program; bounded wait
  task automatic frame(input logic [63:0] v, input int nb, input int fill, input int drop);
    int k;
    host.send(v, nb, fill, drop);
    k = 0;
    repeat (8) @(negedge clock);
    while (busy_flag_q !== 1'b0 && k < 1000) begin
      @(negedge clock);
      k++;
    end
    check("busy_done", 16'(busy_flag_q), 16'h0000);
    repeat (6) @(negedge clock);
  endtask : frame

  task automatic wren();
    frame(64'h06, 1, 0, 0);
    check("latch_set", 16'(write_enable_latch_q), 16'h0001);
  endtask : wren

  task automatic t_wrap();
    clear();
    wren();
    frame(64'h02_0012FE_112233, 7, 0, 0);
    check("wrap_fe", 16'(got[8'hFE]), 16'h0011);
    check("wrap_ff", 16'(got[8'hFF]), 16'h0022);
    check("wrap_00", 16'(got[8'h00]), 16'h0033);
    check("untouched", 16'(got[8'h01]), 16'h00FF);
    check("page", got_hi, 16'h0012);
    check("count", 16'(nwr), 16'h0003);
    check("latch_clr", 16'(write_enable_latch_q), 16'h0000);
    len3 = blen;
  endtask : t_wrap

  // One byte takes the shorter program time
  task automatic t_single();
    clear();
    wren();
    frame(64'h02_003456_A5, 5, 0, 0);
    check("single", 16'(got[8'h56]), 16'h00A5);
    check("count", 16'(nwr), 16'h0001);
    check("time_gap", 16'(len3 - blen), 16'(PP - BP));
  endtask : t_single

  // No latch, partial byte, short address, protected array: nothing written
  task automatic t_refuse();
    clear();
    frame(64'h02_001000_77, 5, 0, 0);
    wren();
    frame(64'h02_001000_7788, 6, 0, 3);
    check("part_latch", 16'(write_enable_latch_q), 16'h0000);
    wren();
    frame(64'h02_0010, 3, 0, 0);
    check("addr_latch", 16'(write_enable_latch_q), 16'h0000);
    array_protected = 1'b1;
    wren();
    frame(64'h02_001000_77, 5, 0, 0);
    check("prot_latch", 16'(write_enable_latch_q), 16'h0000);
    array_protected = 1'b0;
    check("none", 16'(nwr), 16'h0000);
  endtask : t_refuse

  // 258 bytes from an aligned start: the last 256 stay
  task automatic t_over();
    clear();
    for (int j = 0; j < 258; j++) exp_b[j % 256] = 8'(j >> 1);
    wren();
    frame(64'h02_002000, 4, 258, 0);
    for (int i = 0; i < 256; i++) check("over", 16'(got[i]), 16'(exp_b[i]));
    check("count", 16'(nwr), 16'h0100);
  endtask : t_over

  task automatic t_seq();
    clear();
    frame(64'hAF_004020_11, 5, 0, 0);
    check("refused", 16'(nwr), 16'h0000);
    wren();
    frame(64'hAD_004010_C3, 5, 0, 0);
    check("first", 16'(got[8'h10]), 16'h00C3);
    check("first_pg", got_hi, 16'h0040);
    check("seq_on", 16'(seq_mode_q), 16'h0001);
    frame(64'hAF_5A6B, 3, 0, 0);
    check("next", 16'(got[8'h11]), 16'h006B);
    frame(64'hAD_7C, 2, 0, 0);
    check("third", 16'(got[8'h12]), 16'h007C);
    check("count", 16'(nwr), 16'h0003);
    check("status", 16'(status_q), 16'h0006);
    frame(64'h04, 1, 0, 0);
    check("exit", 16'(status_q), 16'h0000);
  endtask : t_seq

  // Main sequence: reset for 16 cycles, then the scenarios
  initial begin
    rst_n = 1'b1;
    array_protected = 1'b0;
    mismatches = 0;
    comparisons = 0;
    nwr = 0;
    blen = 0;
    len3 = 0;
    got_hi = 16'h0000;
    // Reset falls after time zero so the link-side clear sees a real edge
    #1 rst_n = 1'b0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (8) @(negedge clock);
    t_wrap();
    t_single();
    t_refuse();
    t_over();
    t_seq();
    print_verdict();
  end

  // Watchdog: about two and a half times the expected run
  initial begin
    #800000;
    mismatches++;
    print_verdict();
  end
endmodule : serial_flash_program_control_tb

`default_nettype wire

// [tb/sfpc_host.sv]
// SPI host model: mode 0 frames, MSB first, 125 ns link clock.
// Assumes the bench spaces frames; sck stands still between them.
`timescale 1ns/1ps
`default_nettype none

module sfpc_host (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_si
);
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b0;
    spi_si = 1'b0;
    // A select rise after time zero presets the frame marker without a race
    #1 spi_cs_n = 1'b1;
  end

  // Fixed bytes from v, then fill bytes of a counted pattern, less drop bits
  task automatic send(input logic [63:0] v, input int nb, input int fill, input int drop);
    int n;
    int j;
    logic [7:0] b;
    n = (nb + fill) * 8 - drop;
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      j = i / 8 - nb;
      b = (j < 0) ? v[(nb - 1 - i / 8) * 8 +: 8] : 8'(j >> 1);
      spi_si = b[7 - i % 8];
      #62.5 spi_sck = 1'b1;
      #62.5 spi_sck = 1'b0;
    end
    #62.5 spi_cs_n = 1'b1;
    // Released line: no stale value left behind
    spi_si = ~spi_si;
  endtask : send
endmodule : sfpc_host

`default_nettype wire

// [tb/sfpc_top_chk.sv]
// Checker for the program control block, bound to its top module.
// Assumes the core clock domain only; link pins are watched through their effects.
`timescale 1ns/1ps
`default_nettype none

module sfpc_top_chk #(
  parameter int PP_CYCLES = 20,
  parameter int BP_CYCLES = 5
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  input wire logic array_protected,
  input wire sfpc_pkg::sfpc_wr_t arr_wr_q,
  input wire logic arr_wr_valid_q,
  input wire logic [7:0] status_q,
  input wire logic busy_flag_q,
  input wire logic write_enable_latch_q,
  input wire logic seq_mode_q
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Writes within one busy span; must never pass a page
  logic [9:0] wr_cnt_q;
  logic [9:0] wr_cnt_d;
  assign wr_cnt_d = !busy_flag_q ? 10'h000 : wr_cnt_q + {9'h000, arr_wr_valid_q};
  always_ff @(posedge clock) begin
    if (!rst_n) wr_cnt_q <= 10'h000;
    else wr_cnt_q <= wr_cnt_d;
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_status;
    status_q == {5'h00, seq_mode_q, write_enable_latch_q, busy_flag_q};
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");
  property p_wr_busy;
    arr_wr_valid_q |-> busy_flag_q;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write while idle");
  property p_start_latch;
    $rose(busy_flag_q) |-> write_enable_latch_q;
  endproperty
  a_start_latch: assert property (p_start_latch) else $error("program without latch");
  property p_busy_end;
    $rose(busy_flag_q) |-> busy_flag_q [*4] ##[1:400] !busy_flag_q;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy length wrong");
  property p_seq_latch;
    $fell(busy_flag_q) && seq_mode_q |-> write_enable_latch_q;
  endproperty
  a_seq_latch: assert property (p_seq_latch) else $error("latch lost in seq");
  property p_latch_seq;
    $fell(write_enable_latch_q) |-> !seq_mode_q;
  endproperty
  a_latch_seq: assert property (p_latch_seq) else $error("seq kept after clear");
  property p_seq_one;
    arr_wr_valid_q && seq_mode_q |=> !arr_wr_valid_q [*8];
  endproperty
  a_seq_one: assert property (p_seq_one) else $error("seq wrote twice");
  property p_same_page;
    arr_wr_valid_q && $past(arr_wr_valid_q) |-> arr_wr_q.addr[23:8] == $past(arr_wr_q.addr[23:8]);
  endproperty
  a_same_page: assert property (p_same_page) else $error("write left page");
  property p_max_page;
    wr_cnt_q <= 10'h100;
  endproperty
  a_max_page: assert property (p_max_page) else $error("over a page written");
  c_page: cover property (wr_cnt_q == 10'h100);
  c_seq: cover property (arr_wr_valid_q && seq_mode_q);
  c_abort: cover property ($fell(write_enable_latch_q) && !busy_flag_q);
endmodule : sfpc_top_chk

bind sfpc_top sfpc_top_chk #(.PP_CYCLES(PP_CYCLES), .BP_CYCLES(BP_CYCLES)) u_chk (
  .clock(clock), .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
  .array_protected(array_protected), .arr_wr_q(arr_wr_q), .arr_wr_valid_q(arr_wr_valid_q),
  .status_q(status_q), .busy_flag_q(busy_flag_q),
  .write_enable_latch_q(write_enable_latch_q), .seq_mode_q(seq_mode_q));

`default_nettype wire
